// [rtl/ufct_pkg.sv]
package ufct_pkg;

  // Register indices on the 4-bit register port
  localparam logic [3:0] ADDR_TX_IRQ_THR = 4'h0;
  localparam logic [3:0] ADDR_RX_IRQ_THR = 4'h1;
  localparam logic [3:0] ADDR_FLOW_HIGH = 4'h2;
  localparam logic [3:0] ADDR_FLOW_LOW = 4'h3;
  localparam logic [3:0] ADDR_BAUD_FRAC = 4'h4;
  localparam logic [3:0] ADDR_TURN_DELAY = 4'h5;
  localparam logic [3:0] ADDR_ENH_FEAT = 4'h6;
  localparam logic [3:0] ADDR_ADV_CTRL2 = 4'h7;
  localparam logic [3:0] ADDR_RESUME1 = 4'h8;
  localparam logic [3:0] ADDR_RESUME2 = 4'h9;
  localparam logic [3:0] ADDR_PAUSE1 = 4'hA;
  localparam logic [3:0] ADDR_PAUSE2 = 4'hB;
  localparam logic [3:0] ADDR_IRQ_STATUS = 4'hC;
  localparam logic [3:0] ADDR_IRQ_MASK = 4'hD;
  localparam logic [3:0] ADDR_FLOW_STATE = 4'hE;

  // Field positions
  localparam int ENH_TX_HI = 3;
  localparam int ENH_TX_LO = 2;
  localparam int ENH_RX_HI = 1;
  localparam int ENH_RX_LO = 0;
  localparam int ADV_NINE_BIT = 0;
  localparam int ADV_DIR_SEL = 3;
  localparam int PRESC_HI = 3;

  // Interrupt status bit positions
  localparam int IRQ_TX_TRIG = 0;
  localparam int IRQ_RX_TRIG = 1;
  localparam int IRQ_PAUSE_RX = 2;
  localparam int IRQ_RESUME_RX = 3;
  localparam int IRQ_TURN_DONE = 4;
  localparam int IRQ_BITS = 5;

  // Reset values
  localparam logic [7:0] RST_LEVEL = 8'h00;
  localparam logic [7:0] RST_CHAR = 8'h00;
  localparam logic [3:0] RST_ENH = 4'h0;
  localparam logic [3:0] RST_PRESC = 4'h0;
  localparam logic [7:0] RST_TURN = 8'h00;

  // Flow-control selection codes, two bits each
  localparam logic [1:0] SEL_NONE = 2'b00;
  localparam logic [1:0] SEL_FIRST = 2'b10;
  localparam logic [1:0] SEL_SECOND = 2'b01;
  localparam logic [1:0] SEL_BOTH = 2'b11;

  // Largest and smallest FIFO fill that a level code may express
  localparam logic [7:0] LEVEL_MAX = 8'h80;
  localparam logic [7:0] LEVEL_MIN = 8'h01;

  // Decode a threshold code: 0x00 and 0x01 both mean one, clamp at 128
  function automatic logic [7:0] ufct_level(input logic [7:0] code);
    logic [7:0] v;
    v = code;
    if (code < LEVEL_MIN)
    begin
      v = LEVEL_MIN;
    end
    else if (code > LEVEL_MAX)
    begin
      v = LEVEL_MAX;
    end
    return v;
  endfunction

endpackage

// [rtl/ufct_turnaround.sv]
module ufct_turnaround
(
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  // Control
  input wire logic nine_bit_i,
  input wire logic [7:0] delay_i,
  // Transmitter status
  input wire logic tx_active_i,
  input wire logic tx_last_bit_i,
  input wire logic bit_tick_i,
  // Direction result
  output logic dir_tx_o,
  output logic done_o
);
  import ufct_pkg::*;

  logic [7:0] count_r;
  logic counting_r;

  ////////////////////////////////////////////////////////////////////////
  // Direction and countdown; new traffic cancels a pending turnaround
  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_b_i)
    begin
      dir_tx_o <= 1'b0;
      count_r <= RST_TURN;
      counting_r <= 1'b0;
      done_o <= 1'b0;
    end
    else
    begin
      done_o <= 1'b0;
      if (!nine_bit_i)
      begin
        dir_tx_o <= 1'b0;
        counting_r <= 1'b0;
      end
      else if (tx_active_i && !tx_last_bit_i)
      begin
        dir_tx_o <= 1'b1; // RULE12
        counting_r <= 1'b0;
      end
      else if (tx_last_bit_i)
      begin
        // Zero delay turns the line round at once
        if (delay_i == 8'h00)
        begin
          dir_tx_o <= 1'b0; // RULE13
          done_o <= 1'b1;
        end
        else
        begin
          count_r <= delay_i;
          counting_r <= 1'b1;
        end
      end
      else if (counting_r && bit_tick_i)
      begin
        // One count per serial bit time
        count_r <= count_r - 8'h01; // RULE14
        if (count_r == 8'h01)
        begin
          counting_r <= 1'b0;
          dir_tx_o <= 1'b0; // RULE13
          done_o <= 1'b1;
        end
      end
    end
  end

endmodule

// [rtl/ufct_top.sv]
// Notes on behaviour
// RULE1: Upper select bits pick sent pause/resume chars: none, first, second, both.
// RULE2: Lower select bits pick receive compare: off, first pair, second pair.
// RULE3: Lower 11 with upper 10 or 01 accepts either char of each kind.
// RULE4: All four set: send both chars, recognise only the full pair.
// RULE5: Matched pause/resume chars are control, never passed on as data.
// RULE6: Transmit trigger code gives level 1..128, codes 0 and 1 mean one.
// RULE7: Receive trigger code gives level 1..128, codes 0 and 1 mean one.
// RULE8: Thresholds and triggers act only in the 128-byte FIFO mode.
// RULE9: High threshold code 1..128 stops the remote sender.
// RULE10: Low threshold code 1..128 restarts the remote sender.
// RULE11: Prescaler holds four bits in low nibble, reset zero, upper reserved.
// RULE12: Nine-bit mode drives the chosen RTS or DTR pin as line direction.
// RULE13: After last bit, count down delay; at zero drive direction low.
// RULE14: Each turnaround count lasts one serial bit time.
// RULE15: Flow selection lives in enhanced feature bits 3:0, reset zero.
// RULE16: Bit 0 of control two enables nine-bit multidrop mode.
// RULE17: Bit 3 of control two picks RTS (0) or DTR (1) pin.
// RULE18: Pause at high threshold, release only at low threshold.
// RULE19: Prescaler is a sixteenths fraction of the divisor, zero means none.
module ufct_top
(
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  // Register port
  input wire logic [3:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  // FIFO status from the datapath
  input wire logic fifo_128_mode_i,
  input wire logic [7:0] tx_fifo_level_i,
  input wire logic [7:0] rx_fifo_level_i,
  // Received character stream
  input wire logic rx_char_valid_i,
  input wire logic [7:0] rx_char_i,
  // Control characters to the transmitter
  output logic ctl_char_valid_o,
  output logic [7:0] ctl_char_o,
  input wire logic ctl_char_ready_i,
  // Transmitter status
  input wire logic tx_active_i,
  input wire logic tx_last_bit_i,
  input wire logic bit_tick_i,
  // Results
  output logic rx_ctrl_char_o,
  output logic remote_paused_o,
  output logic local_pause_o,
  output logic tx_trig_o,
  output logic rx_trig_o,
  output logic [ufct_pkg::PRESC_HI:0] baud_frac_o,
  output logic rts_dir_o,
  output logic dtr_dir_o,
  output logic irq_o
);
  import ufct_pkg::*;

  typedef enum logic [1:0] {TX_IDLE, TX_FIRST, TX_SECOND} ufct_txs_e;

  logic [7:0] tx_thr_r, rx_thr_r, high_thr_r, low_thr_r, turn_r;
  logic [7:0] res1_r, res2_r, pau1_r, pau2_r;
  logic [3:0] enh_r, presc_r;
  logic nine_bit_r, dir_sel_r;
  logic [IRQ_BITS-1:0] status_r, mask_r, ev_set;
  logic [1:0] tx_sel, rx_sel;
  logic pend_pause_r, pend_resume_r, sending_pause_r;
  ufct_txs_e txs_r;
  logic half_res_r, half_pau_r;
  logic m_res1, m_res2, m_pau1, m_pau2, got_res, got_pau, is_ctrl;
  logic dir_tx, turn_done, pause_rise, pause_fall;

  assign tx_sel = enh_r[ENH_TX_HI:ENH_TX_LO]; // RULE15
  assign rx_sel = enh_r[ENH_RX_HI:ENH_RX_LO]; // RULE15

  ////////////////////////////////////////////////////////////////////////
  // Register writes; reserved bits are dropped on the way in
  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_b_i)
    begin
      tx_thr_r <= RST_LEVEL;
      rx_thr_r <= RST_LEVEL;
      high_thr_r <= RST_LEVEL;
      low_thr_r <= RST_LEVEL;
      turn_r <= RST_TURN;
      presc_r <= RST_PRESC;
      enh_r <= RST_ENH;
      nine_bit_r <= 1'b0;
      dir_sel_r <= 1'b0;
      res1_r <= RST_CHAR;
      res2_r <= RST_CHAR;
      pau1_r <= RST_CHAR;
      pau2_r <= RST_CHAR;
      mask_r <= '0;
    end
    else if (reg_wr_i)
    begin
      case (reg_addr_i)
        ADDR_TX_IRQ_THR: tx_thr_r <= reg_wdata_i;
        ADDR_RX_IRQ_THR: rx_thr_r <= reg_wdata_i;
        ADDR_FLOW_HIGH: high_thr_r <= reg_wdata_i;
        ADDR_FLOW_LOW: low_thr_r <= reg_wdata_i;
        ADDR_BAUD_FRAC: presc_r <= reg_wdata_i[PRESC_HI:0]; // RULE11
        ADDR_TURN_DELAY: turn_r <= reg_wdata_i;
        ADDR_ENH_FEAT: enh_r <= reg_wdata_i[ENH_TX_HI:0];
        ADDR_ADV_CTRL2:
        begin
          nine_bit_r <= reg_wdata_i[ADV_NINE_BIT]; // RULE16
          dir_sel_r <= reg_wdata_i[ADV_DIR_SEL]; // RULE17
        end
        ADDR_RESUME1: res1_r <= reg_wdata_i;
        ADDR_RESUME2: res2_r <= reg_wdata_i;
        ADDR_PAUSE1: pau1_r <= reg_wdata_i;
        ADDR_PAUSE2: pau2_r <= reg_wdata_i;
        ADDR_IRQ_MASK: mask_r <= reg_wdata_i[IRQ_BITS-1:0];
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read data stands only in the cycle after the strobe
  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_b_i)
    begin
      reg_rdata_o <= 8'h00;
    end
    else if (!reg_rd_i)
    begin
      reg_rdata_o <= 8'h00;
    end
    else
    begin
      case (reg_addr_i)
        ADDR_TX_IRQ_THR: reg_rdata_o <= tx_thr_r;
        ADDR_RX_IRQ_THR: reg_rdata_o <= rx_thr_r;
        ADDR_FLOW_HIGH: reg_rdata_o <= high_thr_r;
        ADDR_FLOW_LOW: reg_rdata_o <= low_thr_r;
        ADDR_BAUD_FRAC: reg_rdata_o <= {4'h0, presc_r}; // RULE11
        ADDR_TURN_DELAY: reg_rdata_o <= turn_r;
        ADDR_ENH_FEAT: reg_rdata_o <= {4'h0, enh_r};
        ADDR_ADV_CTRL2: reg_rdata_o <= {4'h0, dir_sel_r, 2'b00, nine_bit_r};
        ADDR_RESUME1: reg_rdata_o <= res1_r;
        ADDR_RESUME2: reg_rdata_o <= res2_r;
        ADDR_PAUSE1: reg_rdata_o <= pau1_r;
        ADDR_PAUSE2: reg_rdata_o <= pau2_r;
        ADDR_IRQ_STATUS: reg_rdata_o <= {3'b000, status_r};
        ADDR_IRQ_MASK: reg_rdata_o <= {3'b000, mask_r};
        ADDR_FLOW_STATE:
          reg_rdata_o <= {4'h0, rts_dir_o, dtr_dir_o, local_pause_o,
            remote_paused_o};
        default: reg_rdata_o <= 8'h00;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Trigger levels; the 32-byte mode uses its own scheme elsewhere
  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_b_i)
    begin
      tx_trig_o <= 1'b0;
      rx_trig_o <= 1'b0;
    end
    else
    begin
      tx_trig_o <= fifo_128_mode_i && // RULE8
        (tx_fifo_level_i <= ufct_level(tx_thr_r)); // RULE6
      rx_trig_o <= fifo_128_mode_i && // RULE8
        (rx_fifo_level_i >= ufct_level(rx_thr_r)); // RULE7
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Receive fill hysteresis between the high and low thresholds
  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_b_i)
    begin
      local_pause_o <= 1'b0;
    end
    else if (!fifo_128_mode_i)
    begin
      local_pause_o <= 1'b0; // RULE8
    end
    else if (rx_fifo_level_i >= ufct_level(high_thr_r))
    begin
      local_pause_o <= 1'b1; // RULE9 RULE18
    end
    else if (rx_fifo_level_i <= ufct_level(low_thr_r))
    begin
      local_pause_o <= 1'b0; // RULE10 RULE18
    end
  end

  assign pause_rise = fifo_128_mode_i && !local_pause_o &&
    (rx_fifo_level_i >= ufct_level(high_thr_r));
  assign pause_fall = local_pause_o && fifo_128_mode_i &&
    (rx_fifo_level_i < ufct_level(high_thr_r)) &&
    (rx_fifo_level_i <= ufct_level(low_thr_r));

  ////////////////////////////////////////////////////////////////////////
  // Pending requests; a newer request replaces an unsent older one
  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_b_i)
    begin
      pend_pause_r <= 1'b0;
      pend_resume_r <= 1'b0;
    end
    else if (tx_sel == SEL_NONE)
    begin
      pend_pause_r <= 1'b0; // RULE1
      pend_resume_r <= 1'b0;
    end
    else if (pause_rise)
    begin
      pend_pause_r <= 1'b1;
      pend_resume_r <= 1'b0;
    end
    else if (pause_fall)
    begin
      pend_resume_r <= 1'b1;
      pend_pause_r <= 1'b0;
    end
    else if (txs_r == TX_IDLE && (pend_pause_r || pend_resume_r))
    begin
      pend_pause_r <= 1'b0;
      pend_resume_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Control character sender; a character stands until it is taken
  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_b_i)
    begin
      txs_r <= TX_IDLE;
      ctl_char_valid_o <= 1'b0;
      ctl_char_o <= 8'h00;
      sending_pause_r <= 1'b0;
    end
    else
    begin
      case (txs_r)
        TX_IDLE:
        begin
          if (tx_sel != SEL_NONE && (pend_pause_r || pend_resume_r))
          begin
            sending_pause_r <= pend_pause_r;
            ctl_char_valid_o <= 1'b1;
            if (tx_sel == SEL_SECOND)
            begin
              ctl_char_o <= pend_pause_r ? pau2_r : res2_r; // RULE1
              txs_r <= TX_SECOND;
            end
            else
            begin
              ctl_char_o <= pend_pause_r ? pau1_r : res1_r; // RULE1
              txs_r <= TX_FIRST;
            end
          end
        end
        TX_FIRST:
        begin
          if (ctl_char_ready_i)
          begin
            if (tx_sel == SEL_BOTH)
            begin
              // Second char of the pair follows straight on
              ctl_char_o <= sending_pause_r ? pau2_r : res2_r; // RULE4
              txs_r <= TX_SECOND;
            end
            else
            begin
              ctl_char_valid_o <= 1'b0;
              txs_r <= TX_IDLE;
            end
          end
        end
        TX_SECOND:
        begin
          if (ctl_char_ready_i)
          begin
            ctl_char_valid_o <= 1'b0;
            txs_r <= TX_IDLE;
          end
        end
        default:
        begin
          ctl_char_valid_o <= 1'b0;
          txs_r <= TX_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Receive comparison; a pair is only whole with its second char
  assign m_res1 = rx_char_i == res1_r;
  assign m_res2 = rx_char_i == res2_r;
  assign m_pau1 = rx_char_i == pau1_r;
  assign m_pau2 = rx_char_i == pau2_r;

  always_comb
  begin
    got_res = 1'b0;
    got_pau = 1'b0;
    is_ctrl = 1'b0;
    if (rx_char_valid_i)
    begin
      case (rx_sel)
        SEL_FIRST:
        begin
          got_res = m_res1; // RULE2
          got_pau = m_pau1;
        end
        SEL_SECOND:
        begin
          got_res = m_res2; // RULE2
          got_pau = m_pau2;
        end
        SEL_BOTH:
        begin
          if (tx_sel == SEL_BOTH)
          begin
            got_res = half_res_r && m_res2; // RULE4
            got_pau = half_pau_r && m_pau2;
          end
          else
          begin
            got_res = m_res1 || m_res2; // RULE3
            got_pau = m_pau1 || m_pau2;
          end
        end
        default: ;
      endcase
      // Halves of a pair are control too and never reach the FIFO
      is_ctrl = got_res || got_pau || (rx_sel == SEL_BOTH &&
        tx_sel == SEL_BOTH && (m_res1 || m_pau1)); // RULE5
    end
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_b_i)
    begin
      half_res_r <= 1'b0;
      half_pau_r <= 1'b0;
      remote_paused_o <= 1'b0;
      rx_ctrl_char_o <= 1'b0;
    end
    else
    begin
      rx_ctrl_char_o <= is_ctrl; // RULE5
      if (rx_char_valid_i)
      begin
        half_res_r <= m_res1; // RULE4
        half_pau_r <= m_pau1;
      end
      if (rx_sel == SEL_NONE)
      begin
        remote_paused_o <= 1'b0;
      end
      else if (got_pau)
      begin
        remote_paused_o <= 1'b1;
      end
      else if (got_res)
      begin
        remote_paused_o <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Line turnaround and direction pin selection
  ufct_turnaround u_turn
  (
    .clk_sys_i(clk_sys_i),
    .rst_b_i(rst_b_i),
    .nine_bit_i(nine_bit_r),
    .delay_i(turn_r),
    .tx_active_i(tx_active_i),
    .tx_last_bit_i(tx_last_bit_i),
    .bit_tick_i(bit_tick_i),
    .dir_tx_o(dir_tx),
    .done_o(turn_done)
  );

  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_b_i)
    begin
      rts_dir_o <= 1'b0;
      dtr_dir_o <= 1'b0;
      baud_frac_o <= RST_PRESC;
    end
    else
    begin
      rts_dir_o <= nine_bit_r && !dir_sel_r && dir_tx; // RULE12 RULE17
      dtr_dir_o <= nine_bit_r && dir_sel_r && dir_tx; // RULE12 RULE17
      // Zero adds no fraction to the divisor
      baud_frac_o <= presc_r; // RULE19
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Sticky status, write one to clear; a new event beats the clear
  always_comb
  begin
    ev_set = '0;
    ev_set[IRQ_TX_TRIG] = tx_trig_o;
    ev_set[IRQ_RX_TRIG] = rx_trig_o;
    ev_set[IRQ_PAUSE_RX] = got_pau;
    ev_set[IRQ_RESUME_RX] = got_res;
    ev_set[IRQ_TURN_DONE] = turn_done;
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_b_i)
    begin
      status_r <= '0;
      irq_o <= 1'b0;
    end
    else
    begin
      if (reg_wr_i && reg_addr_i == ADDR_IRQ_STATUS)
      begin
        status_r <= (status_r & ~reg_wdata_i[IRQ_BITS-1:0]) | ev_set;
      end
      else
      begin
        status_r <= status_r | ev_set;
      end
      irq_o <= |(status_r & mask_r);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks
  a_tx_none_quiet: assert property (@(posedge clk_sys_i) // RULE1
    disable iff (!rst_b_i) tx_sel == SEL_NONE && txs_r == TX_IDLE
    |=> !ctl_char_valid_o)
    else $error("control char sent with transmit flow off");
  a_both_pair: assert property (@(posedge clk_sys_i) // RULE4
    disable iff (!rst_b_i) txs_r == TX_FIRST && ctl_char_ready_i &&
    tx_sel == SEL_BOTH |=> ctl_char_valid_o && txs_r == TX_SECOND)
    else $error("second char of pair not sent");
  a_rx_first_pause: assert property (@(posedge clk_sys_i) // RULE2
    disable iff (!rst_b_i) rx_char_valid_i && rx_sel == SEL_FIRST &&
    m_pau1 && !m_res1 |=> remote_paused_o && rx_ctrl_char_o)
    else $error("first pause char not recognised");
  a_rx_either: assert property (@(posedge clk_sys_i) // RULE3
    disable iff (!rst_b_i) rx_char_valid_i && rx_sel == SEL_BOTH &&
    tx_sel != SEL_BOTH && m_pau2 |=> remote_paused_o)
    else $error("second pause char not accepted");
  a_trig_mode: assert property (@(posedge clk_sys_i) // RULE8
    disable iff (!rst_b_i) !fifo_128_mode_i |=> !tx_trig_o && !rx_trig_o)
    else $error("trigger outside 128-byte mode");
  a_rx_trig_lvl: assert property (@(posedge clk_sys_i) // RULE7
    disable iff (!rst_b_i) fifo_128_mode_i && rx_thr_r == 8'h00 &&
    rx_fifo_level_i == 8'h01 |=> rx_trig_o)
    else $error("code zero is not level one");
  a_tx_trig_lvl: assert property (@(posedge clk_sys_i) // RULE6
    disable iff (!rst_b_i) fifo_128_mode_i && tx_thr_r == 8'h80 &&
    tx_fifo_level_i == 8'h80 |=> tx_trig_o)
    else $error("code 0x80 is not level 128");
  a_hyst_hold: assert property (@(posedge clk_sys_i) // RULE18
    disable iff (!rst_b_i) local_pause_o && fifo_128_mode_i &&
    rx_fifo_level_i > ufct_level(low_thr_r) |=> local_pause_o)
    else $error("pause released above low threshold");
  a_high_set: assert property (@(posedge clk_sys_i) // RULE9
    disable iff (!rst_b_i) fifo_128_mode_i &&
    rx_fifo_level_i >= ufct_level(high_thr_r) |=> local_pause_o)
    else $error("pause not raised at high threshold");
  a_presc_rsvd: assert property (@(posedge clk_sys_i) // RULE11
    disable iff (!rst_b_i) reg_rd_i && reg_addr_i == ADDR_BAUD_FRAC
    |=> reg_rdata_o[7:4] == 4'h0 && reg_rdata_o[3:0] == $past(presc_r))
    else $error("prescaler read back wrong");
  a_dir_off: assert property (@(posedge clk_sys_i) // RULE16
    disable iff (!rst_b_i) !nine_bit_r |=> ##1 !rts_dir_o && !dtr_dir_o)
    else $error("direction driven outside nine-bit mode");
  a_turn_zero: assert property (@(posedge clk_sys_i) // RULE13
    disable iff (!rst_b_i) nine_bit_r && tx_last_bit_i && turn_r == 8'h00
    |=> !dir_tx)
    else $error("zero delay did not turn line round");
  a_dir_sel: assert property (@(posedge clk_sys_i) // RULE17
    disable iff (!rst_b_i) dir_sel_r |=> !rts_dir_o)
    else $error("RTS driven while DTR selected");

  c_pause_sent: cover property (@(posedge clk_sys_i)
    txs_r == TX_SECOND && ctl_char_ready_i && sending_pause_r);
  c_pair_rx: cover property (@(posedge clk_sys_i) got_pau && half_pau_r);
  c_turn_done: cover property (@(posedge clk_sys_i) turn_done);
  c_irq: cover property (@(posedge clk_sys_i) irq_o);

endmodule

// [bench/ufct_tx_model.sv]
module ufct_tx_model
(
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  // Control character link
  input wire logic valid_i,
  input wire logic [7:0] char_i,
  output logic ready_o,
  // Pacing and record
  input wire logic slow_i,
  output logic [3:0] count_o,
  output logic [7:0] last_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // Slow pacing takes a char on alternate cycles, like a busy shifter
  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_b_i)
      ready_o <= 1'b0;
    else
      ready_o <= slow_i ? ~ready_o : 1'b1;
  end
  // Taken chars go straight to the line, never into the payload path
  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_b_i)
    begin
      count_o <= 4'h0;
      last_o <= 8'h00;
    end
    else if (valid_i && ready_o)
    begin
      count_o <= count_o + 4'h1;
      last_o <= char_i;
    end
  end
endmodule

// [bench/tb.sv]
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import ufct_pkg::*;
  logic clk_sys_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00, rxl = 8'h00, txl = 8'h00, rxc = 8'h00;
  logic wr = 1'b0, rd = 1'b0, m128 = 1'b0, rxv = 1'b0;
  logic act = 1'b0, last = 1'b0, tick = 1'b0;
  logic slow = 1'b1;
  logic cv, cr, rxctl, rpause, lpause, ttrig, rtrig, rts, dtr, irq;
  logic [7:0] cc, rdat, lastc;
  logic [3:0] frac, cnt;
  int err_count = 0;
  int total_checks = 0;
  ufct_top ufct_top_i (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i),
    .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd),
    .reg_rdata_o(rdat), .fifo_128_mode_i(m128), .tx_fifo_level_i(txl),
    .rx_fifo_level_i(rxl), .rx_char_valid_i(rxv), .rx_char_i(rxc),
    .ctl_char_valid_o(cv), .ctl_char_o(cc), .ctl_char_ready_i(cr),
    .tx_active_i(act), .tx_last_bit_i(last), .bit_tick_i(tick),
    .rx_ctrl_char_o(rxctl), .remote_paused_o(rpause),
    .local_pause_o(lpause), .tx_trig_o(ttrig), .rx_trig_o(rtrig),
    .baud_frac_o(frac), .rts_dir_o(rts), .dtr_dir_o(dtr), .irq_o(irq));
  ufct_tx_model ufct_tx_model_i (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i),
    .valid_i(cv), .char_i(cc), .ready_o(cr), .slow_i(slow),
    .count_o(cnt), .last_o(lastc));
  always #4 clk_sys_i = ~clk_sys_i;
  //////////////////////////////////////////////////////////////////////////
  // Shared checks and bus cycles
  task chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task chkb(input logic got, input logic exp);
    chk({7'h00, got}, {7'h00, exp});
  endtask
  task wait_n(input int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask
  task wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys_i);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk_sys_i);
    wr <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe, so sample there
  task rd_chk(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk_sys_i);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk_sys_i);
    rd <= 1'b0;
    #1;
    chk(rdat, e);
  endtask
  task pulse_tick;
    @(posedge clk_sys_i);
    tick <= 1'b1;
    @(posedge clk_sys_i);
    tick <= 1'b0;
  endtask
  //////////////////////////////////////////////////////////////////////////
  // Scenarios
  task t_regs;
    for (int i = 0; i < 16; i++)
      rd_chk(i[3:0], 8'h00);
    wr_reg(ADDR_BAUD_FRAC, 8'hFF);
    rd_chk(ADDR_BAUD_FRAC, 8'h0F);
    chk({4'h0, frac}, 8'h0F);
    wr_reg(4'hF, 8'h55);
    rd_chk(4'hF, 8'h00);
  endtask
  task lvl(input logic [7:0] r, input logic [7:0] t, input logic er,
           input logic et);
    @(posedge clk_sys_i);
    rxl <= r;
    txl <= t;
    wait_n(3);
    chkb(rtrig, er);
    chkb(ttrig, et);
  endtask
  // Boundary codes: zero and one both mean one, 0x80 means 128
  task t_trig;
    @(posedge clk_sys_i);
    m128 <= 1'b1;
    lvl(8'h00, 8'h01, 1'b0, 1'b1);
    lvl(8'h01, 8'h02, 1'b1, 1'b0);
    wr_reg(ADDR_RX_IRQ_THR, 8'h80);
    wr_reg(ADDR_TX_IRQ_THR, 8'h01);
    lvl(8'h7F, 8'h01, 1'b0, 1'b1);
    lvl(8'h80, 8'h02, 1'b1, 1'b0);
    // Top code on the transmit side: a full FIFO still triggers
    wr_reg(ADDR_TX_IRQ_THR, 8'h80);
    lvl(8'h80, 8'h80, 1'b1, 1'b1);
    @(posedge clk_sys_i);
    m128 <= 1'b0;
    lvl(8'h80, 8'h00, 1'b0, 1'b0);
    lvl(8'h00, 8'h00, 1'b0, 1'b0);
  endtask
  // Pause pair at the high mark, resume pair only back at the low mark
  task t_flow;
    for (int i = 0; i < 4; i++)
      wr_reg(ADDR_RESUME1 + i[3:0], 8'h11 + i[7:0]);
    wr_reg(ADDR_FLOW_HIGH, 8'h04);
    wr_reg(ADDR_FLOW_LOW, 8'h02);
    @(posedge clk_sys_i);
    m128 <= 1'b1;
    wr_reg(ADDR_ENH_FEAT, 8'h0C);
    lvl(8'h03, 8'h00, 1'b0, 1'b1);
    chkb(lpause, 1'b0);
    lvl(8'h04, 8'h00, 1'b0, 1'b1);
    wait_n(8);
    chkb(lpause, 1'b1);
    chk({4'h0, cnt}, 8'h02);
    chk(lastc, 8'h14);
    lvl(8'h03, 8'h00, 1'b0, 1'b1);
    wait_n(8);
    chkb(lpause, 1'b1);
    chk({4'h0, cnt}, 8'h02);
    lvl(8'h02, 8'h00, 1'b0, 1'b1);
    wait_n(8);
    chkb(lpause, 1'b0);
    chk({4'h0, cnt}, 8'h04);
    chk(lastc, 8'h12);
  endtask
  task rx_send(input logic [7:0] c, input logic ectl, input logic ep);
    @(posedge clk_sys_i);
    rxv <= 1'b1;
    rxc <= c;
    @(posedge clk_sys_i);
    rxv <= 1'b0;
    #1;
    chkb(rxctl, ectl);
    chkb(rpause, ep);
  endtask
  task t_rx;
    wr_reg(ADDR_ENH_FEAT, 8'h02);
    rx_send(8'h13, 1'b1, 1'b1);
    rx_send(8'h55, 1'b0, 1'b1);
    rx_send(8'h12, 1'b0, 1'b1);
    rx_send(8'h11, 1'b1, 1'b0);
    wr_reg(ADDR_ENH_FEAT, 8'h0B);
    rx_send(8'h14, 1'b1, 1'b1);
    rx_send(8'h12, 1'b1, 1'b0);
    wr_reg(ADDR_ENH_FEAT, 8'h0F);
    rx_send(8'h13, 1'b1, 1'b0);
    rx_send(8'h14, 1'b1, 1'b1);
    rx_send(8'h11, 1'b1, 1'b1);
    rx_send(8'h12, 1'b1, 1'b0);
  endtask
  // Direction holds through the countdown, one bit tick per count
  task t_turn;
    wr_reg(ADDR_ADV_CTRL2, 8'h01);
    wr_reg(ADDR_TURN_DELAY, 8'h02);
    wr_reg(ADDR_IRQ_MASK, 8'h10);
    @(posedge clk_sys_i);
    act <= 1'b1;
    wait_n(3);
    chkb(rts, 1'b1);
    chkb(dtr, 1'b0);
    @(posedge clk_sys_i);
    act <= 1'b0;
    last <= 1'b1;
    @(posedge clk_sys_i);
    last <= 1'b0;
    pulse_tick();
    wait_n(3);
    chkb(rts, 1'b1);
    chkb(irq, 1'b0);
    pulse_tick();
    wait_n(4);
    chkb(rts, 1'b0);
    chkb(irq, 1'b1);
    wr_reg(ADDR_IRQ_STATUS, 8'h10);
    wait_n(2);
    chkb(irq, 1'b0);
    wr_reg(ADDR_ADV_CTRL2, 8'h09);
    @(posedge clk_sys_i);
    act <= 1'b1;
    wait_n(3);
    chkb(dtr, 1'b1);
    chkb(rts, 1'b0);
    // Zero delay turns the line round straight after the last bit
    wr_reg(ADDR_TURN_DELAY, 8'h00);
    @(posedge clk_sys_i);
    act <= 1'b0;
    last <= 1'b1;
    @(posedge clk_sys_i);
    last <= 1'b0;
    wait_n(3);
    chkb(dtr, 1'b0);
    @(posedge clk_sys_i);
    act <= 1'b1;
    wait_n(3);
    chkb(dtr, 1'b1);
    wr_reg(ADDR_ADV_CTRL2, 8'h08);
    wait_n(3);
    chkb(dtr, 1'b0);
  endtask
  //////////////////////////////////////////////////////////////////////////
  task results;
    $display("checks=%0d errors=%0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // Whole sequence runs in a few hundred cycles; the watchdog is generous
  initial
  begin
    #50000;
    err_count++;
    results();
  end
  initial
  begin
    repeat (6) @(posedge clk_sys_i);
    rst_b_i <= 1'b1;
    t_regs();
    t_trig();
    t_flow();
    t_rx();
    t_turn();
    results();
  end
endmodule
